// ===== rtl/scr_regs.sv
/*
 * Strap configuration and test register bank.
 * Holds the indexed test, clock select and strap registers and drives
 * the debug pixel mux, the clock select pins and the decoded controls.
 * Assumes the host decodes the index and data port strobes, all inputs
 * are synchronous to sys_clk_i, and the strap bus is valid in reset.
 */
`timescale 1ns/1ps
`default_nettype none

module scr_regs (
  input  wire logic              sys_clk_i,          // Host bus clock.
  input  wire logic              reset_n_i,          // Sync reset, active low.
  input  wire logic              index_wr_i,         // Index port write strobe.
  input  wire logic              data_wr_i,          // Data port write strobe.
  input  wire logic              data_rd_i,          // Data port read strobe.
  input  wire logic [7:0]        host_wdata_i,       // Host write data.
  input  wire logic [23:0]       memory_data_bus_i,  // Strap bus in reset.
  input  wire logic              misc_output_wr_i,   // Misc output register write.
  input  wire logic              coproc_busy_i,      // Co-processor busy.
  input  wire logic              coproc_start_i,     // Co-processor function start.
  input  wire scr_pkg::scr_dbg_t dbg_wincur_i,       // Window/cursor debug group.
  input  wire scr_pkg::scr_dbg_t dbg_refresh_i,      // Refresh debug group.
  input  wire scr_pkg::scr_dbg_t dbg_mmedia_i,       // Multimedia debug group.
  input  wire logic [7:0]        pixel_normal_i,     // Normal pixel data 23..16.
  output logic [7:0]             index_o,            // Index register.
  output logic [7:0]             host_rdata_o,       // Data port read data.
  output logic [7:0]             pixel_hi_o,         // Pixel pins 23..16.
  output logic                   global_test_o,      // Global test enable.
  output logic                   coproc_ready_o,     // Co-processor ready.
  output logic                   coproc_exec_o,      // Co-processor may run.
  output logic [3:0]             clock_select_pins_o,// Clock select pins.
  output logic [7:0]             misc_output_register_o, // Misc output image.
  output logic [7:0]             ext_d_o,            // Extended register D.
  output logic [7:0]             extended_reg_ten_o, // Extended register ten.
  output scr_pkg::scr_strap_t    strap_o,            // Decoded strap controls.
  output logic [19:0]            rom_base_o          // ROM decode base.
);
  import scr_pkg::*;

  // ---------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------
  logic [7:0]  index_reg;     // Index register.
  logic [7:0]  chip_test_reg; // Chip test and debug control.
  logic [7:0]  coproc_reg;    // Co-processor test control.
  logic [7:0]  vclk_reg;      // Video clock select.
  logic [7:0]  misc_reg;      // Misc output image.
  logic [7:0]  extd_reg;      // Extended register D.
  logic [7:0]  extten_reg;    // Extended register ten.
  logic [23:0] strap_reg;     // Captured straps.
  logic [7:0]  rdata_reg;     // Read data.
  logic [7:0]  pixel_reg;     // Pixel pin drive.
  logic        ready_reg;     // Co-processor ready.
  logic        exec_reg;      // Co-processor run permit.
  scr_strap_t  strap_out_reg; // Decoded straps.

  // ---------------------------------------------------------------
  // Decode.
  // ---------------------------------------------------------------
  wire wr_chip   = data_wr_i && (index_reg == SCR_IDX_CHIP_TEST);   // Test write.
  wire wr_coproc = data_wr_i && (index_reg == SCR_IDX_COPROC_TEST); // Speed write.
  wire wr_vclk   = data_wr_i && (index_reg == SCR_IDX_VCLK_SEL);    // Clock write.
  wire wr_extd   = data_wr_i && (index_reg == SCR_IDX_EXT_D);       // Ext D write.
  wire wr_extten = data_wr_i && (index_reg == SCR_IDX_EXT_TEN);     // Ext ten write.
  wire speed_test = coproc_reg[SCR_CP_SPEED_TEST];                  // Speed test on.
  wire debug_on   = chip_test_reg[SCR_CT_DEBUG_EN];                 // Debug routing on.
  wire [2:0] dbg_sel = chip_test_reg[2:0];                          // Debug select.

  // Read mux; strap registers read their captured values.
  logic [7:0] rd_mux;
  always_comb begin
    if (index_reg == SCR_IDX_CHIP_TEST) begin
      rd_mux = chip_test_reg;
    end else if (index_reg == SCR_IDX_COPROC_TEST) begin
      rd_mux = coproc_reg;
    end else if (index_reg == SCR_IDX_VCLK_SEL) begin
      rd_mux = vclk_reg;
    end else if (index_reg == SCR_IDX_STRAP_LOW) begin
      rd_mux = strap_reg[7:0];
    end else if (index_reg == SCR_IDX_STRAP_MID) begin
      rd_mux = strap_reg[15:8];
    end else if (index_reg == SCR_IDX_STRAP_HIGH) begin
      rd_mux = strap_reg[23:16];
    end else if (index_reg == SCR_IDX_EXT_D) begin
      rd_mux = extd_reg;
    end else if (index_reg == SCR_IDX_EXT_TEN) begin
      rd_mux = extten_reg;
    end else begin
      rd_mux = SCR_RST_BYTE; // Unmapped index reads zero.
    end
  end

  // Debug pixel mux; reserved code falls back to normal data.
  scr_dbg_t dbg_sel_grp;
  logic     dbg_valid;
  always_comb begin
    dbg_sel_grp = '0;
    dbg_valid   = 1'b1;
    case (dbg_sel)
      SCR_DBG_WINCUR:  dbg_sel_grp = dbg_wincur_i;
      SCR_DBG_REFRESH: dbg_sel_grp = dbg_refresh_i;
      SCR_DBG_MMEDIA:  dbg_sel_grp = dbg_mmedia_i;
      default:         dbg_valid   = 1'b0;
    endcase
  end
  wire [7:0] pixel_next = (debug_on && dbg_valid) ? dbg_sel_grp : pixel_normal_i;

  // Bus type decode from the low strap byte.
  wire [2:0] bus_code = strap_reg[4:2];
  wire is_vl  = (bus_code == SCR_BUS_VL386) || (bus_code == SCR_BUS_VL486A)
             || (bus_code == SCR_BUS_VL486B);
  wire is_pci = (bus_code == SCR_BUS_PCI);
  wire is_isa = (bus_code == SCR_BUS_ISA);

  scr_strap_t strap_next;
  always_comb begin
    strap_next.rom_wide       = strap_reg[0];
    strap_next.rom_wide_route = strap_reg[0] && (is_pci || is_isa);
    strap_next.addon_card     = strap_reg[1];
    strap_next.bus_vl         = is_vl;
    strap_next.bus_pci        = is_pci;
    strap_next.bus_isa        = is_isa;
    strap_next.bus_reserved   = !(is_vl || is_pci || is_isa);
    strap_next.dram_org       = strap_reg[7:5];
    strap_next.dram_reserved  = (strap_reg[7:5] == 3'h7);
    strap_next.pix_wide       = strap_reg[8];
    strap_next.aux_dac_cs     = strap_reg[9] && is_vl;
    strap_next.dac_24bit      = strap_reg[9] && (is_pci || is_isa);
    strap_next.rom_decode_en  = strap_reg[10];
    strap_next.rom_size       = strap_reg[12:11];
    strap_next.split_cas      = strap_reg[13];
    strap_next.fast_write     = extten_reg[SCR_ET_FAST_WRITE];
    strap_next.slow_bus       = strap_reg[15];
    strap_next.devsel_timing  = strap_reg[16] ? SCR_DEVSEL_SLOW : SCR_DEVSEL_MED;
    strap_next.multi_func     = strap_reg[17];
    strap_next.alt_rom_addr   = strap_reg[18];
  end

  // ---------------------------------------------------------------
  // Strap capture: sampled on every reset cycle, frozen after.
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      strap_reg <= memory_data_bus_i;
    end
  end

  // ---------------------------------------------------------------
  // Writable registers.
  // ---------------------------------------------------------------
  // Index register; software sets it before a data access.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      index_reg <= SCR_RST_BYTE;
    end else if (index_wr_i) begin
      index_reg <= host_wdata_i;
    end
  end

  // Test and co-processor control registers.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      chip_test_reg <= SCR_RST_BYTE;
      coproc_reg    <= SCR_RST_BYTE;
    end else begin
      if (wr_chip) begin
        chip_test_reg <= host_wdata_i;
      end
      if (wr_coproc) begin
        coproc_reg <= host_wdata_i;
      end
    end
  end

  // Clock select with its mirrors in misc output and extended D.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      vclk_reg <= SCR_RST_BYTE;
      misc_reg <= SCR_RST_BYTE;
      extd_reg <= SCR_RST_BYTE;
    end else begin
      if (wr_vclk) begin
        vclk_reg <= host_wdata_i;
        misc_reg[SCR_MISC_CLOCK_SELECT_PINS_LO +: 2] <= host_wdata_i[1:0];
        extd_reg[SCR_EXTD_CSEL2] <= host_wdata_i[2];
      end else begin
        if (misc_output_wr_i) begin
          misc_reg <= host_wdata_i;
          vclk_reg[1:0] <= host_wdata_i[SCR_MISC_CLOCK_SELECT_PINS_LO +: 2];
        end
        if (wr_extd) begin
          extd_reg <= host_wdata_i;
          vclk_reg[2] <= host_wdata_i[SCR_EXTD_CSEL2];
        end
      end
    end
  end

  // Extended ten; fast write bit loads from the strap after reset.
  logic fw_load_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      extten_reg  <= SCR_RST_BYTE;
      fw_load_reg <= 1'b1;
    end else if (fw_load_reg) begin
      extten_reg[SCR_ET_FAST_WRITE] <= strap_reg[SCR_MID_FAST_WRITE + 8];
      fw_load_reg <= 1'b0;
    end else if (wr_extten) begin
      extten_reg <= host_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // Output flops.
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_reg     <= SCR_RST_BYTE;
      pixel_reg     <= SCR_RST_BYTE;
      ready_reg     <= 1'b0;
      exec_reg      <= 1'b0;
      strap_out_reg <= '0;
    end else begin
      if (data_rd_i) begin
        rdata_reg <= rd_mux;
      end
      pixel_reg     <= pixel_next;
      ready_reg     <= speed_test || !coproc_busy_i;
      exec_reg      <= coproc_start_i && !speed_test;
      strap_out_reg <= strap_next;
    end
  end

  assign index_o                = index_reg;
  assign host_rdata_o           = rdata_reg;
  assign pixel_hi_o             = pixel_reg;
  assign global_test_o          = chip_test_reg[SCR_CT_GLOBAL_TEST];
  assign coproc_ready_o         = ready_reg;
  assign coproc_exec_o          = exec_reg;
  assign clock_select_pins_o    = vclk_reg[3:0];
  assign misc_output_register_o = misc_reg;
  assign ext_d_o                = extd_reg;
  assign extended_reg_ten_o     = extten_reg;
  assign strap_o                = strap_out_reg;
  assign rom_base_o             = SCR_ROM_BASE;

endmodule

`default_nettype wire

// ===== rtl/scr_pkg.sv
/*
 * Package for the strap-configuration and test register bank.
 * Holds register indices, field positions, reset values and encodings.
 * Assumes an 8-bit indexed host port pair and one host bus clock.
 */
package scr_pkg;

  // ---------------------------------------------------------------
  // Register indices behind the data port.
  // ---------------------------------------------------------------
  localparam logic [7:0] SCR_IDX_CHIP_TEST   = 8'h03; // Chip test and debug control.
  localparam logic [7:0] SCR_IDX_COPROC_TEST = 8'h04; // Co-processor test control.
  localparam logic [7:0] SCR_IDX_VCLK_SEL    = 8'h06; // Video clock select.
  localparam logic [7:0] SCR_IDX_STRAP_LOW   = 8'h07; // Strap configuration low.
  localparam logic [7:0] SCR_IDX_STRAP_MID   = 8'h08; // Strap configuration mid.
  localparam logic [7:0] SCR_IDX_STRAP_HIGH  = 8'h09; // Strap configuration high.
  localparam logic [7:0] SCR_IDX_EXT_D       = 8'h0D; // Extended register D mirror.
  localparam logic [7:0] SCR_IDX_EXT_TEN     = 8'h10; // Extended register ten.

  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [7:0] SCR_RST_BYTE = 8'h00; // Common reset value.

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int SCR_CT_GLOBAL_TEST = 7; // Global test enable.
  localparam int SCR_CT_DEBUG_EN    = 6; // Debug routing enable.
  localparam int SCR_CP_SPEED_TEST  = 0; // Co-processor speed test.
  localparam int SCR_MISC_CLOCK_SELECT_PINS_LO   = 2; // Misc output clock field base.
  localparam int SCR_EXTD_CSEL2     = 5; // Extended D clock bit.
  localparam int SCR_ET_FAST_WRITE  = 1; // Extended ten fast write bit.
  localparam int SCR_MID_FAST_WRITE = 6; // Strap mid fast write bit.

  // ---------------------------------------------------------------
  // Encodings.
  // ---------------------------------------------------------------
  localparam logic [2:0] SCR_DBG_WINCUR  = 3'h4; // Window/cursor to sequencer.
  localparam logic [2:0] SCR_DBG_REFRESH = 3'h5; // Refresh address.
  localparam logic [2:0] SCR_DBG_MMEDIA  = 3'h6; // Multimedia to sequencer.
  localparam logic [2:0] SCR_BUS_VL386   = 3'h1; // 386 VL bus.
  localparam logic [2:0] SCR_BUS_VL486A  = 3'h2; // 486 VL bus.
  localparam logic [2:0] SCR_BUS_VL486B  = 3'h3; // 486 VL bus.
  localparam logic [2:0] SCR_BUS_PCI     = 3'h4; // PCI bus.
  localparam logic [2:0] SCR_BUS_ISA     = 3'h7; // ISA bus.
  localparam logic [1:0] SCR_DEVSEL_MED  = 2'h1; // Medium decode timing.
  localparam logic [1:0] SCR_DEVSEL_SLOW = 2'h2; // Slow decode timing.
  localparam logic [19:0] SCR_ROM_BASE   = 20'hC0000; // Default ROM base.

  // Debug group for the pixel pins.
  typedef struct packed {
    logic [2:0] command;  // Sequencer command.
    logic [2:0] source;   // Address source.
    logic       state;    // Internal state.
    logic       frame;    // Frame signal.
  } scr_dbg_t;

  // Decoded strap controls.
  typedef struct packed {
    logic       rom_wide;       // Two ROMs, 16-bit data.
    logic       rom_wide_route; // ROM width routing in effect.
    logic       addon_card;     // Enable through add-on port.
    logic       bus_vl;         // VL bus.
    logic       bus_pci;        // PCI bus.
    logic       bus_isa;        // ISA bus.
    logic       bus_reserved;   // Reserved bus code.
    logic [2:0] dram_org;       // DRAM organisation code.
    logic       dram_reserved;  // Reserved DRAM code.
    logic       pix_wide;       // 16-bit DAC pixel bus.
    logic       aux_dac_cs;     // Chip-select style DAC strobes.
    logic       dac_24bit;      // 24-bit DAC port.
    logic       rom_decode_en;  // ROM decode enable.
    logic [1:0] rom_size;       // ROM size code.
    logic       split_cas;      // Split column strobes.
    logic       fast_write;     // Zero-wait write.
    logic       slow_bus;       // Bus at or below 33MHz.
    logic [1:0] devsel_timing;  // PCI decode timing field.
    logic       multi_func;     // Header multi-function flag.
    logic       alt_rom_addr;   // Alternate PCI ROM addressing.
  } scr_strap_t;

endpackage

// ===== verif/scr_regs_props.sv
/*
 * Checker for the strap configuration and test register bank.
 * Assumes it is bound to scr_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module scr_regs_props (
  input wire logic              sys_clk_i,              // Host bus clock.
  input wire logic              reset_n_i,              // Sync reset, active low.
  input wire logic              data_wr_i,              // Data port write strobe.
  input wire logic [7:0]        host_wdata_i,           // Host write data.
  input wire logic              misc_output_wr_i,       // Misc output write strobe.
  input wire logic              coproc_busy_i,          // Co-processor busy.
  input wire logic              coproc_start_i,         // Function start request.
  input wire scr_pkg::scr_dbg_t dbg_wincur_i,           // Window/cursor group.
  input wire scr_pkg::scr_dbg_t dbg_refresh_i,          // Refresh group.
  input wire scr_pkg::scr_dbg_t dbg_mmedia_i,           // Multimedia group.
  input wire logic [7:0]        pixel_normal_i,         // Normal pixel byte.
  input wire logic [7:0]        index_o,                // Index register.
  input wire logic [7:0]        pixel_hi_o,             // Pixel pins 23..16.
  input wire logic              global_test_o,          // Global test enable.
  input wire logic              coproc_ready_o,         // Co-processor ready.
  input wire logic              coproc_exec_o,          // Co-processor may run.
  input wire logic [3:0]        clock_select_pins_o,    // Clock select pins.
  input wire logic [7:0]        misc_output_register_o, // Misc output image.
  input wire logic [7:0]        ext_d_o,                // Extended register D.
  input wire logic [7:0]        extended_reg_ten_o,     // Extended register ten.
  input wire scr_pkg::scr_strap_t strap_o               // Decoded straps.
);
  import scr_pkg::*;

  // ---------------------------------------------------------------
  // Shadow state of the test registers.
  // ---------------------------------------------------------------
  logic [7:0] chip_reg; // Shadow of the chip test register.
  logic       spd_reg;  // Shadow of the speed test bit.
  logic [7:0] pix_exp;  // Pixel byte that the mux should pick.
  wire        vclk_wr = data_wr_i && index_o == SCR_IDX_VCLK_SEL; // Clock select write.
  wire        chip_wr = data_wr_i && index_o == SCR_IDX_CHIP_TEST; // Chip test write.
  wire        strap_wr = data_wr_i && index_o >= 8'h07 && index_o <= 8'h09; // Strap write.

  // Debug routing picks a group only for the three defined codes.
  assign pix_exp = !chip_reg[SCR_CT_DEBUG_EN] ? pixel_normal_i :
                   chip_reg[2:0] == SCR_DBG_WINCUR  ? dbg_wincur_i :
                   chip_reg[2:0] == SCR_DBG_REFRESH ? dbg_refresh_i :
                   chip_reg[2:0] == SCR_DBG_MMEDIA  ? dbg_mmedia_i : pixel_normal_i;

  // Shadows follow data port writes.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      chip_reg <= 8'h00;
      spd_reg  <= 1'b0;
    end else begin
      if (chip_wr) chip_reg <= host_wdata_i;
      if (data_wr_i && index_o == SCR_IDX_COPROC_TEST) spd_reg <= host_wdata_i[0];
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_vclk_wr;
    vclk_wr;
  endsequence

  a_vclk_pins:
    assert property (s_vclk_wr |=> clock_select_pins_o == $past(host_wdata_i[3:0]))
      else $error("Clock pins did not follow the select write.");
  a_vclk_mirror:
    assert property (s_vclk_wr |=> misc_output_register_o[3:2] == $past(host_wdata_i[1:0])
      && ext_d_o[5] == $past(host_wdata_i[2])) else $error("Clock mirror bits wrong.");
  a_misc_to_pins:
    assert property (misc_output_wr_i && !vclk_wr |=>
      clock_select_pins_o[1:0] == $past(host_wdata_i[3:2])) else $error("Misc not mirrored.");
  a_global_test:
    assert property (chip_wr |=> global_test_o == $past(host_wdata_i[7]))
      else $error("Global test output wrong.");
  a_speed_ready:
    assert property (1'b1 |=> coproc_ready_o == $past(spd_reg || !coproc_busy_i))
      else $error("Co-processor ready wrong.");
  a_exec_gate:
    assert property (1'b1 |=> coproc_exec_o == $past(coproc_start_i && !spd_reg))
      else $error("Co-processor run gate wrong.");
  a_pixel_route:
    assert property (1'b1 |=> pixel_hi_o == $past(pix_exp))
      else $error("Pixel pin routing wrong.");
  a_strap_ro:
    assert property (strap_wr && $stable(extended_reg_ten_o) |=> $stable(strap_o))
      else $error("Strap changed after a write.");
endmodule

bind scr_regs scr_regs_props scr_regs_props_i (.sys_clk_i, .reset_n_i, .data_wr_i,
  .host_wdata_i, .misc_output_wr_i, .coproc_busy_i, .coproc_start_i, .dbg_wincur_i,
  .dbg_refresh_i, .dbg_mmedia_i, .pixel_normal_i, .index_o, .pixel_hi_o, .global_test_o,
  .coproc_ready_o, .coproc_exec_o, .clock_select_pins_o, .misc_output_register_o,
  .ext_d_o, .extended_reg_ten_o, .strap_o);

`default_nettype wire

// ===== verif/scr_host_model.sv
/*
 * Host software model that reaches the bank through the index/data ports.
 * Assumes one host clock; strobes change 1 ns after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module scr_host_model (
  input  wire logic       sys_clk_i,  // Host bus clock.
  input  wire logic [7:0] rdata_i,    // Data port read data.
  output logic            index_wr_o, // Index port strobe.
  output logic            data_wr_o,  // Data port write strobe.
  output logic            data_rd_o,  // Data port read strobe.
  output logic            misc_wr_o,  // Misc output strobe.
  output logic [7:0]      wdata_o     // Host write data.
);
  // Idle bus at time zero.
  initial begin
    {index_wr_o, data_wr_o, data_rd_o, misc_wr_o} = 4'h0;
    wdata_o = 8'h00;
  end

  // Index cycle; every data access is preceded by one.
  task automatic idx_cycle(input logic [7:0] idx);
    @(posedge sys_clk_i);
    #1;
    index_wr_o = 1'b1;
    wdata_o    = idx;
    @(posedge sys_clk_i);
    #1;
    index_wr_o = 1'b0;
  endtask

  // Indexed register write; the bus then shows the inverse, not stale data.
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
    idx_cycle(idx);
    data_wr_o = 1'b1;
    wdata_o   = val;
    @(posedge sys_clk_i);
    #1;
    data_wr_o = 1'b0;
    wdata_o   = ~val;
  endtask

  // Indexed register read; data is taken after the strobe's edge.
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] val);
    idx_cycle(idx);
    data_rd_o = 1'b1;
    wdata_o   = ~idx;
    @(posedge sys_clk_i);
    #1;
    data_rd_o = 1'b0;
    val       = rdata_i;
  endtask

  // Misc output register write.
  task automatic misc_write(input logic [7:0] val);
    @(posedge sys_clk_i);
    #1;
    misc_wr_o = 1'b1;
    wdata_o   = val;
    @(posedge sys_clk_i);
    #1;
    misc_wr_o = 1'b0;
    wdata_o   = ~val;
  endtask
endmodule

`default_nettype wire

// ===== verif/testbench.sv
/*
 * Self-checking testbench for the strap configuration and test bank.
 * Assumes the host model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  import scr_pkg::*;

  localparam logic [23:0] STRAP0 = 24'h05C56B; // Strap pattern for the first reset.
  logic        sys_clk_i, reset_n_i, index_wr_i, data_wr_i, data_rd_i;
  logic        misc_output_wr_i, coproc_busy_i, coproc_start_i;
  logic        global_test_o, coproc_ready_o, coproc_exec_o;
  logic [7:0]  host_wdata_i, pixel_normal_i, index_o, host_rdata_o, pixel_hi_o, rd;
  logic [7:0]  misc_output_register_o, ext_d_o, extended_reg_ten_o;
  logic [23:0] memory_data_bus_i, s;
  logic [3:0]  clock_select_pins_o;
  logic [19:0] rom_base_o;
  logic [2:0]  bb;
  scr_dbg_t    dbg_wincur_i, dbg_refresh_i, dbg_mmedia_i;
  scr_strap_t  strap_o;
  logic [7:0]  codes [5] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h04}; // Debug codes to try.
  int          bad_count = 0;
  int          n_tests = 0;

  scr_regs scr_regs_i (.sys_clk_i, .reset_n_i, .index_wr_i, .data_wr_i, .data_rd_i,
    .host_wdata_i, .memory_data_bus_i, .misc_output_wr_i, .coproc_busy_i,
    .coproc_start_i, .dbg_wincur_i, .dbg_refresh_i, .dbg_mmedia_i, .pixel_normal_i,
    .index_o, .host_rdata_o, .pixel_hi_o, .global_test_o, .coproc_ready_o,
    .coproc_exec_o, .clock_select_pins_o, .misc_output_register_o, .ext_d_o,
    .extended_reg_ten_o, .strap_o, .rom_base_o);
  scr_host_model scr_host_model_i (.sys_clk_i, .rdata_i(host_rdata_o),
    .index_wr_o(index_wr_i), .data_wr_o(data_wr_i), .data_rd_o(data_rd_i),
    .misc_wr_o(misc_output_wr_i), .wdata_o(host_wdata_i));

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers.
  // ---------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset for 3 cycles with a strap pattern, then change the bus.
  task automatic do_reset(input logic [23:0] st);
    @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b0;
    memory_data_bus_i = st;
    repeat (3) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    memory_data_bus_i = ~st;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    scr_host_model_i.read_reg(idx, rd);
    `CHK(nm, e, rd)
    `CHK("index", idx, index_o)
  endtask

  // Pixel byte for a chip test code, pins 23..16 built field by field.
  function automatic logic [7:0] pix_exp(input logic [7:0] c);
    scr_dbg_t g;
    g = c == 8'h44 ? dbg_wincur_i : c == 8'h45 ? dbg_refresh_i : dbg_mmedia_i;
    return (c[6] && c[2] && c[1:0] != 2'h3) ? {g.command, g.source, g.state, g.frame}
                                              : pixel_normal_i;
  endfunction

  // ---------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    memory_data_bus_i = STRAP0;
    {coproc_busy_i, coproc_start_i} = 2'h0;
    {dbg_wincur_i, dbg_refresh_i, dbg_mmedia_i, pixel_normal_i} = 32'h965AE13C;
    do_reset(STRAP0);
    rd_chk("chip_test", SCR_IDX_CHIP_TEST, 8'h00);
    rd_chk("strap_mid", SCR_IDX_STRAP_MID, STRAP0[15:8]);
    `CHK("rom_wide", STRAP0[0], strap_o.rom_wide)
    `CHK("dram_org", STRAP0[7:5], strap_o.dram_org)
    `CHK("pix_wide", STRAP0[8], strap_o.pix_wide)
    `CHK("rom_dec", STRAP0[10], strap_o.rom_decode_en)
    `CHK("rom_base", 20'hC0000, rom_base_o)
    `CHK("split_cas", STRAP0[13], strap_o.split_cas)
    `CHK("slow_bus", STRAP0[15], strap_o.slow_bus)
    `CHK("alt_rom", STRAP0[18], strap_o.alt_rom_addr)
    rd_chk("ext_ten", SCR_IDX_EXT_TEN, {6'h00, STRAP0[14], 1'b0});
    // Strap registers and an unmapped place ignore writes.
    for (int i = 7; i <= 9; i++) scr_host_model_i.write_reg(8'(i), 8'hFF);
    scr_host_model_i.write_reg(8'h55, 8'hFF);
    rd_chk("unmapped", 8'h55, 8'h00);
    rd_chk("strap_low", SCR_IDX_STRAP_LOW, STRAP0[7:0]);
    rd_chk("strap_high", SCR_IDX_STRAP_HIGH, STRAP0[23:16]);
    scr_host_model_i.write_reg(SCR_IDX_EXT_TEN, 8'h00);
    `CHK("ext_ten_o", 8'h00, extended_reg_ten_o)
    rd_chk("strap_mid", SCR_IDX_STRAP_MID, STRAP0[15:8]);
    `CHK("fast_wr", 1'b0, strap_o.fast_write)
    // Clock select pins and their two mirrors.
    scr_host_model_i.write_reg(SCR_IDX_VCLK_SEL, 8'hA5);
    `CHK("pins", 4'h5, clock_select_pins_o)
    `CHK("misc", 6'h18, {misc_output_register_o[3:2], ext_d_o[5:2]})
    scr_host_model_i.misc_write(8'h0C);
    rd_chk("vclk", SCR_IDX_VCLK_SEL, 8'hA7);
    scr_host_model_i.write_reg(SCR_IDX_EXT_D, 8'h00);
    rd_chk("vclk", SCR_IDX_VCLK_SEL, 8'hA3);
    scr_host_model_i.write_reg(SCR_IDX_VCLK_SEL, 8'hF2);
    rd_chk("vclk", SCR_IDX_VCLK_SEL, 8'hF2);
    `CHK("pins", 4'h2, clock_select_pins_o)
    // Global test and debug routing onto the pixel pins.
    scr_host_model_i.write_reg(SCR_IDX_CHIP_TEST, 8'h80);
    `CHK("gtest", 1'b1, global_test_o)
    foreach (codes[k]) begin
      scr_host_model_i.write_reg(SCR_IDX_CHIP_TEST, codes[k]);
      repeat (2) @(posedge sys_clk_i);
      #1;
      `CHK("pixel", pix_exp(codes[k]), pixel_hi_o)
    end
    `CHK("gtest", 1'b0, global_test_o)
    // Speed test makes the co-processor skip and stay ready.
    {coproc_busy_i, coproc_start_i} = 2'h3;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("ready_exec", 2'h1, {coproc_ready_o, coproc_exec_o})
    scr_host_model_i.write_reg(SCR_IDX_COPROC_TEST, 8'h01);
    @(posedge sys_clk_i);
    #1;
    `CHK("ready_exec", 2'h2, {coproc_ready_o, coproc_exec_o})
    // Every bus type code, each captured by a fresh reset.
    for (int b = 0; b < 8; b++) begin
      bb = b[2:0];
      s = {6'h00, bb[1:0], 8'h02, 3'h0, bb, bb[0], 1'b1};
      do_reset(s);
      `CHK("pci", bb == 3'h4, strap_o.bus_pci)
      `CHK("isa", bb == 3'h7, strap_o.bus_isa)
      `CHK("rom_route", bb == 3'h4 || bb == 3'h7, strap_o.rom_wide_route)
      `CHK("addon", bb[0], strap_o.addon_card)
      `CHK("devsel", bb[0] ? 2'h2 : 2'h1, strap_o.devsel_timing)
      `CHK("multi_fn", bb[1], strap_o.multi_func)
      if (bb != 3'h0 && bb != 3'h5 && bb != 3'h6) begin
        `CHK("vl", bb < 3'h4, strap_o.bus_vl)
        `CHK("dac_cs", {bb < 3'h4, bb > 3'h3}, {strap_o.aux_dac_cs, strap_o.dac_24bit})
      end
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
